// [hw/scfs_defines.vh]
// constants for the seat clean and fail-safe controller
`ifndef SCFS_DEFINES_VH
`define SCFS_DEFINES_VH

// clock and time base
`define SCFS_CLK_PERIOD_NS 10
`define SCFS_MS_NS 1000000
`define SCFS_MS_CYCLES (`SCFS_MS_NS / `SCFS_CLK_PERIOD_NS)

// times in milliseconds
`define SCFS_REQ_HOLD_MS 16'd500
`define SCFS_EXTRA_MS 16'd1000
`define SCFS_HOLDOFF_MS 16'd2000
`define SCFS_DONE_FB_MS 16'd2000
`define SCFS_FLASH_MS 16'd250

// register byte offsets
`define SCFS_OFF_CFG 8'h00
`define SCFS_OFF_STROKE 8'h04
`define SCFS_OFF_CMD 8'h08
`define SCFS_OFF_STATUS 8'h0C
`define SCFS_OFF_IRQ_STAT 8'h14
`define SCFS_OFF_IRQ_CLR 8'h18
`define SCFS_OFF_IRQ_EN 8'h1C

// cfg fields
`define SCFS_CFG_COILS_LSB 0
`define SCFS_CFG_VAR_LSB 2
`define SCFS_CFG_USL_BIT 4
`define SCFS_CFG_RST 5'h03
`define SCFS_STROKE_RST 16'h03E8

// interface variants
`define SCFS_VAR_DIGITAL 2'h0
`define SCFS_VAR_ASI 2'h1
`define SCFS_VAR_IOLINK 2'h2

// cmd fields
`define SCFS_CMD_PANEL_BIT 0

// interrupt event bits
`define SCFS_IRQ_W 5
`define SCFS_EV_START 0
`define SCFS_EV_DONE 1
`define SCFS_EV_REFUSED 2
`define SCFS_EV_MODE 3
`define SCFS_EV_FAILSAFE 4

// select press count that arms the burst setting, and the count after which it wraps back to one
`define SCFS_SEL_BURST 4'h4
`define SCFS_SEL_MAX 4'h8

`endif

// [hw/scfs_sync.v]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module scfs_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the last two stages agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_agree
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dout[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

// [hw/scfs_ctrl.v]
// burst seat clean, fail-safe valve state and default feedback controller
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "scfs_defines.vh"
module scfs_ctrl #(
  parameter MS_CYCLES = `SCFS_MS_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire btn_select,
  input wire btn_enter,
  input wire remote_burst_mode,
  input wire burst_req,
  input wire main_coil_req,
  input wire pos_reached,
  input wire err_valid,
  input wire [5:0] err_code,
  output reg main_coil,
  output reg coil_output_one,
  output reg burst_coil,
  output reg deenergized_closed_feedback,
  output reg feedback_input_zero,
  output reg feedback_input_one,
  output reg valve_state,
  output reg burst_active,
  output reg burst_done_fb,
  output reg burst_done_led,
  output reg led_four_flash,
  output reg irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PUSH = 2'd1;
  localparam ST_EXTRA = 2'd2;
  localparam ST_DONE = 2'd3;

  // error codes decide whether the fail-safe output drops
  function fs_drop;
    input [5:0] code;
    input [1:0] variant;
    begin
      case (code)
        6'd16, 6'd19, 6'd20, 6'd21, 6'd22, 6'd31: fs_drop = 1'b1;
        6'd23, 6'd24, 6'd25, 6'd26, 6'd29: fs_drop = (variant != `SCFS_VAR_ASI);
        6'd27: fs_drop = (variant == `SCFS_VAR_DIGITAL);
        6'd30: fs_drop = (variant == `SCFS_VAR_DIGITAL) || (variant == `SCFS_VAR_IOLINK);
        default: fs_drop = 1'b0;
      endcase
    end
  endfunction

  wire [5:0] pins_s;
  wire sel_s = pins_s[0];
  wire ent_s = pins_s[1];
  wire rmode_s = pins_s[2];
  wire req_s = pins_s[3];
  wire mcoil_s = pins_s[4];
  wire pos_s = pins_s[5];

  scfs_sync #(.W(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({pos_reached, main_coil_req, burst_req, remote_burst_mode, btn_enter, btn_select}),
    .dout(pins_s)
  );

  // millisecond enable from the divider
  reg [31:0] div_q;
  reg tick_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q >= MS_CYCLES - 1) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // registers
  reg [4:0] cfg_q;
  reg [15:0] stroke_q;
  reg [`SCFS_IRQ_W-1:0] ist_q;
  reg [`SCFS_IRQ_W-1:0] ien_q;
  wire [1:0] coils = cfg_q[`SCFS_CFG_COILS_LSB+1:`SCFS_CFG_COILS_LSB];
  wire [1:0] variant = cfg_q[`SCFS_CFG_VAR_LSB+1:`SCFS_CFG_VAR_LSB];
  wire usl_present = cfg_q[`SCFS_CFG_USL_BIT];
  wire coils_ok = (coils == 2'd2) || (coils == 2'd3);

  wire wr_en = psel && penable && pready && pwrite;
  wire wr_cfg = wr_en && (paddr == `SCFS_OFF_CFG);
  wire wr_stroke = wr_en && (paddr == `SCFS_OFF_STROKE);
  wire wr_cmd = wr_en && (paddr == `SCFS_OFF_CMD);
  wire wr_clr = wr_en && (paddr == `SCFS_OFF_IRQ_CLR);
  wire wr_ien = wr_en && (paddr == `SCFS_OFF_IRQ_EN);
  wire panel_toggle = wr_cmd && pwdata[`SCFS_CMD_PANEL_BIT];

  // local buttons and remote mode
  reg sel_d1_q;
  reg ent_d1_q;
  reg rmode_d1_q;
  reg [3:0] sel_cnt_q;
  reg burst_en_q;
  wire sel_press = sel_s && !sel_d1_q;
  wire ent_press = ent_s && !ent_d1_q;
  wire rmode_rise = rmode_s && !rmode_d1_q;
  wire rmode_fall = !rmode_s && rmode_d1_q;
  wire locked = rmode_s;
  wire local_toggle = ent_press && (sel_cnt_q == `SCFS_SEL_BURST);
  wire any_toggle = (local_toggle || panel_toggle) && !locked;
  reg burst_en_d;

  always @* begin
    burst_en_d = burst_en_q;
    if (rmode_rise) begin
      burst_en_d = 1'b1;
    end else if (rmode_fall) begin
      burst_en_d = 1'b0;
    end else if (any_toggle) begin
      burst_en_d = !burst_en_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_d1_q <= 1'b0;
      ent_d1_q <= 1'b0;
      rmode_d1_q <= 1'b0;
      sel_cnt_q <= 4'h0;
      burst_en_q <= 1'b0;
    end else begin
      sel_d1_q <= sel_s;
      ent_d1_q <= ent_s;
      rmode_d1_q <= rmode_s;
      burst_en_q <= burst_en_d;
      if (ent_press) begin
        sel_cnt_q <= 4'h0;
      end else if (sel_press) begin
        sel_cnt_q <= (sel_cnt_q == `SCFS_SEL_MAX) ? 4'h1 : sel_cnt_q + 4'h1;
      end
    end
  end

  wire burst_offered = burst_en_q && coils_ok;

  // request qualification: only a held request counts
  reg [15:0] req_ms_q;
  reg req_used_q;
  wire req_long = req_s && (req_ms_q > `SCFS_REQ_HOLD_MS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ms_q <= 16'h0000;
    end else if (!req_s) begin
      req_ms_q <= 16'h0000;
    end else if (tick_q && !req_long) begin
      req_ms_q <= req_ms_q + 16'h0001;
    end
  end

  // burst sequence
  reg [1:0] st_q;
  reg [15:0] ph_ms_q;
  wire fresh_req = req_long && !req_used_q;
  wire start = fresh_req && (st_q == ST_IDLE) && burst_offered;
  wire refused = fresh_req && (st_q == ST_IDLE) && !burst_offered;
  wire push_end = usl_present ? pos_s : (ph_ms_q >= stroke_q);
  wire extra_end = ph_ms_q >= `SCFS_EXTRA_MS;
  wire done_end = ph_ms_q > `SCFS_HOLDOFF_MS;
  reg ev_done;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_used_q <= 1'b0;
    end else if (!req_s) begin
      req_used_q <= 1'b0;
    end else if (start || refused) begin
      req_used_q <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      ph_ms_q <= 16'h0000;
      ev_done <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          ph_ms_q <= 16'h0000;
          if (start) begin
            st_q <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (push_end) begin
            // coil drops here, so the valve returns to its start position
            ph_ms_q <= 16'h0000;
            if (usl_present) begin
              st_q <= ST_DONE;
              ev_done <= 1'b1;
            end else begin
              st_q <= ST_EXTRA;
            end
          end else if (tick_q) begin
            ph_ms_q <= ph_ms_q + 16'h0001;
          end
        end
        ST_EXTRA: begin
          if (extra_end) begin
            ph_ms_q <= 16'h0000;
            st_q <= ST_DONE;
            ev_done <= 1'b1;
          end else if (tick_q) begin
            ph_ms_q <= ph_ms_q + 16'h0001;
          end
        end
        ST_DONE: begin
          if (done_end) begin
            st_q <= ST_IDLE;
          end else if (tick_q) begin
            ph_ms_q <= ph_ms_q + 16'h0001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          ph_ms_q <= 16'h0000;
        end
      endcase
    end
  end

  // flashing indicator for the armed select position
  reg [15:0] flash_ms_q;
  reg flash_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ms_q <= 16'h0000;
      flash_q <= 1'b0;
    end else if (tick_q) begin
      if (flash_ms_q >= `SCFS_FLASH_MS - 16'd1) begin
        flash_ms_q <= 16'h0000;
        flash_q <= !flash_q;
      end else begin
        flash_ms_q <= flash_ms_q + 16'h0001;
      end
    end
  end

  // outputs, all registered
  wire fs_ok = !(err_valid && fs_drop(err_code, variant));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_coil <= 1'b0;
      coil_output_one <= 1'b0;
      burst_coil <= 1'b0;
      deenergized_closed_feedback <= 1'b1;
      feedback_input_zero <= 1'b1;
      feedback_input_one <= 1'b0;
      valve_state <= 1'b1;
      burst_active <= 1'b0;
      burst_done_fb <= 1'b0;
      burst_done_led <= 1'b0;
      led_four_flash <= 1'b0;
    end else begin
      main_coil <= mcoil_s;
      coil_output_one <= mcoil_s;
      burst_coil <= (st_q == ST_PUSH) && !push_end;
      // one mapping, independent of the interface variant
      deenergized_closed_feedback <= !mcoil_s;
      feedback_input_zero <= !mcoil_s;
      feedback_input_one <= mcoil_s;
      valve_state <= fs_ok;
      burst_active <= (st_q == ST_PUSH) || (st_q == ST_EXTRA);
      burst_done_fb <= (st_q == ST_DONE) && !done_end;
      burst_done_led <= (st_q == ST_DONE) && !done_end;
      led_four_flash <= (sel_cnt_q == `SCFS_SEL_BURST) && flash_q;
    end
  end

  // interrupts: set wins over a clear in the same cycle
  reg fs_ok_d1_q;
  wire [`SCFS_IRQ_W-1:0] ev;
  assign ev[`SCFS_EV_START] = start;
  assign ev[`SCFS_EV_DONE] = ev_done;
  assign ev[`SCFS_EV_REFUSED] = refused;
  assign ev[`SCFS_EV_MODE] = (burst_en_d != burst_en_q);
  assign ev[`SCFS_EV_FAILSAFE] = fs_ok_d1_q && !fs_ok;
  wire [`SCFS_IRQ_W-1:0] clr = wr_clr ? pwdata[`SCFS_IRQ_W-1:0] : {`SCFS_IRQ_W{1'b0}};
  wire [`SCFS_IRQ_W-1:0] ist_d = (ist_q & ~clr) | ev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= {`SCFS_IRQ_W{1'b0}};
      ien_q <= {`SCFS_IRQ_W{1'b0}};
      fs_ok_d1_q <= 1'b1;
      irq <= 1'b0;
    end else begin
      ist_q <= ist_d;
      fs_ok_d1_q <= fs_ok;
      if (wr_ien) begin
        ien_q <= pwdata[`SCFS_IRQ_W-1:0];
      end
      irq <= |(ist_d & (wr_ien ? pwdata[`SCFS_IRQ_W-1:0] : ien_q));
    end
  end

  // apb slave: read data prepared in setup, no wait states
  wire [31:0] status = {10'h000, err_valid, err_code, 5'h00, st_q, 2'h0,
    (st_q == ST_IDLE), valve_state, burst_done_fb, burst_active, locked, burst_offered};
  reg [31:0] rdata_d;
  reg rerr_d;
  always @* begin
    rdata_d = 32'h00000000;
    rerr_d = 1'b0;
    case (paddr)
      `SCFS_OFF_CFG: rdata_d = {27'h0000000, cfg_q};
      `SCFS_OFF_STROKE: rdata_d = {16'h0000, stroke_q};
      `SCFS_OFF_CMD: rdata_d = 32'h00000000;
      `SCFS_OFF_STATUS: rdata_d = status;
      `SCFS_OFF_IRQ_STAT: rdata_d = {27'h0000000, ist_q};
      `SCFS_OFF_IRQ_CLR: rdata_d = 32'h00000000;
      `SCFS_OFF_IRQ_EN: rdata_d = {27'h0000000, ien_q};
      default: rerr_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cfg_q <= `SCFS_CFG_RST;
      stroke_q <= `SCFS_STROKE_RST;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rdata_d;
        pslverr <= rerr_d;
      end
      if (wr_cfg) begin
        cfg_q <= pwdata[4:0];
      end
      if (wr_stroke) begin
        stroke_q <= pwdata[15:0];
      end
    end
  end
endmodule

// [test/scfs_ctrl_properties.sv]
// port assertions for the seat clean and fail-safe controller
`timescale 1ns/1ns
module scfs_ctrl_props #(
  parameter MS_CYCLES = 100000
) (
  input wire pclk,
  input wire presetn,
  input wire burst_req,
  input wire err_valid,
  input wire [5:0] err_code,
  input wire burst_coil,
  input wire deenergized_closed_feedback,
  input wire feedback_input_zero,
  input wire feedback_input_one,
  input wire valve_state,
  input wire burst_active,
  input wire burst_done_fb,
  input wire burst_done_led,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] req_q;
  logic [31:0] done_q;
  // run lengths; the raw pin is counted so the sync delay only adds margin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 32'h0;
      done_q <= 32'h0;
    end else begin
      req_q <= burst_req ? req_q + 32'h1 : 32'h0;
      done_q <= burst_done_fb ? done_q + 32'h1 : 32'h0;
    end
  end
  a_fb_open_closed: assert property (feedback_input_one != deenergized_closed_feedback)
    else $error("open and closed feedback agree");
  a_fb_same_map: assert property (feedback_input_zero == deenergized_closed_feedback)
    else $error("closed feedback copies differ");
  a_done_led_pair: assert property (burst_done_fb == burst_done_led)
    else $error("done feedback and indicator differ");
  a_done_min_len: assert property ($fell(burst_done_fb) |-> done_q >= 2000 * MS_CYCLES)
    else $error("done pulse too short");
  a_no_early_burst: assert property ($rose(burst_active) |-> !burst_done_fb)
    else $error("burst during holdoff");
  a_coil_in_burst: assert property (burst_coil |-> burst_active)
    else $error("coil on outside burst");
  a_end_gives_done: assert property ($fell(burst_active) |-> ##[0:2] burst_done_fb)
    else $error("no done after burst");
  a_req_long_hold: assert property ($rose(burst_active) |-> req_q >= 500 * MS_CYCLES)
    else $error("burst from short request");
  a_err_drops: assert property (
    err_valid && (err_code inside {16, 19, 20, 21, 22, 31}) |=> !valve_state)
    else $error("valve state kept on fault");
  a_err_ignored: assert property (
    err_valid && (err_code inside {15, 17, 18, 28, 32}) |=> valve_state)
    else $error("valve state dropped on benign code");
  a_idle_high: assert property (!err_valid |=> valve_state)
    else $error("valve state low without error");
  cover property ($rose(burst_active));
  cover property ($fell(burst_done_fb));
  cover property ($fell(valve_state));
  cover property ($rose(irq));
endmodule

// [test/scfs_plc_model.sv]
// controller-side model: mode bit, coil command, burst request, sensor
`timescale 1ns/1ns
module scfs_plc_model #(
  parameter MS_CYCLES = 10
) (
  input wire pclk,
  input wire burst_coil,
  output logic burst_req,
  output logic remote_burst_mode,
  output logic main_coil_req,
  output logic pos_reached
);
  initial begin
    burst_req = 1'b0;
    remote_burst_mode = 1'b0;
    main_coil_req = 1'b0;
  end
  // seat sensor trails the burst coil by a cycle of travel
  always @(posedge pclk) begin
    pos_reached <= burst_coil;
  end
  // holds less than half a second only when a glitch is wanted
  task automatic req_ms(input int ms);
    burst_req <= 1'b1;
    repeat (ms * MS_CYCLES) @(posedge pclk);
    burst_req <= 1'b0;
  endtask
  task automatic mode(input logic v);
    remote_burst_mode <= v;
  endtask
  task automatic coil(input logic v);
    main_coil_req <= v;
  endtask
endmodule

// [test/scfs_ctrl_tb_top.sv]
// self-checking bench for the seat clean and fail-safe controller
`timescale 1ns/1ns
module scfs_ctrl_tb_top;
  localparam int MS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic btn_select = 1'b0;
  logic btn_enter = 1'b0;
  logic err_valid = 1'b0;
  logic [5:0] err_code = 6'h00;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, main_coil, coil_output_one, burst_coil, dcf, fb0, fb1;
  logic valve_state, burst_active, burst_done_fb, burst_done_led, led_four_flash, irq;
  wire burst_req, remote_burst_mode, main_coil_req, pos_reached;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int act_n = 0;
  int act0 = 0;
  logic fl = 1'b0;
  always #5 pclk = ~pclk;
  scfs_plc_model #(.MS_CYCLES(MS)) plc (.pclk(pclk), .burst_coil(burst_coil),
    .burst_req(burst_req), .remote_burst_mode(remote_burst_mode),
    .main_coil_req(main_coil_req), .pos_reached(pos_reached));
  scfs_ctrl #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_select(btn_select), .btn_enter(btn_enter),
    .remote_burst_mode(remote_burst_mode), .burst_req(burst_req),
    .main_coil_req(main_coil_req), .pos_reached(pos_reached), .err_valid(err_valid),
    .err_code(err_code), .main_coil(main_coil), .coil_output_one(coil_output_one),
    .burst_coil(burst_coil), .deenergized_closed_feedback(dcf),
    .feedback_input_zero(fb0), .feedback_input_one(fb1), .valve_state(valve_state),
    .burst_active(burst_active), .burst_done_fb(burst_done_fb),
    .burst_done_led(burst_done_led), .led_four_flash(led_four_flash), .irq(irq));
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic push(input logic s);
    btn_select <= s;
    btn_enter <= !s;
    repeat (8) @(posedge pclk);
    btn_select <= 1'b0;
    btn_enter <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic drops(input int c, input int v);
    if (c inside {16, 19, 20, 21, 22, 31}) return 1'b1;
    if (c inside {[23:26], 29, 30}) return v != 1;
    return c == 27 && v == 0;
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (burst_active === 1'b1) act_n++;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h00, 0); chk("cfg", 32'h03, rdata);
    apb(0, 8'h04, 0); chk("stroke", 32'h3E8, rdata);
    apb(0, 8'h0C, 0); chk("offered", 0, rdata & 1);
    chk("vstate", 1, valve_state);
    apb(0, 8'h40, 0); chk("slverr", 1, rerr);
    plc.coil(1);
    repeat (10) @(posedge pclk);
    chk("open", 4'b1011, {fb1, dcf, main_coil, coil_output_one});
    plc.coil(0);
    repeat (10) @(posedge pclk);
    chk("closed", 4'b0110, {fb1, dcf, fb0, coil_output_one});
    for (int v = 0; v < 3; v++) begin
      apb(1, 8'h00, 32'h3 | (v << 2));
      for (int c = 15; c < 33; c++) begin
        err_code <= 6'(c);
        err_valid <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("vstate", !drops(c, v), valve_state);
      end
      err_valid <= 1'b0;
    end
    apb(1, 8'h00, 32'h3);
    repeat (4) push(1);
    push(0);
    apb(0, 8'h0C, 0); chk("local on", 1, rdata & 1);
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h0C, 0); chk("one coil", 0, rdata & 1);
    apb(1, 8'h00, 32'h3);
    apb(1, 8'h08, 1);
    apb(0, 8'h0C, 0); chk("panel off", 0, rdata & 1);
    plc.mode(1);
    repeat (10) @(posedge pclk);
    apb(0, 8'h0C, 0); chk("remote on", 3, rdata & 3);
    apb(1, 8'h08, 1);
    apb(0, 8'h0C, 0); chk("panel locked", 3, rdata & 3);
    repeat (4) push(1);
    push(0);
    apb(0, 8'h0C, 0); chk("locked", 3, rdata & 3);
    plc.mode(0);
    repeat (10) @(posedge pclk);
    apb(0, 8'h0C, 0); chk("remote off", 0, rdata & 3);
    repeat (4) push(1);
    // the indicator blinks with a slow half period, so watch a full blink
    fl = 1'b0;
    repeat (600 * MS) begin
      @(posedge pclk);
      fl = fl | led_four_flash;
    end
    chk("flash", 1, fl);
    push(0);
    apb(0, 8'h0C, 0); chk("retoggle", 1, rdata & 1);
    chk("flash off", 0, led_four_flash);
    apb(1, 8'h04, 20);
    plc.req_ms(100);
    repeat (10 * MS) @(posedge pclk);
    chk("glitch", 0, act_n);
    plc.req_ms(600);
    while (burst_active === 1'b1) @(posedge pclk);
    chk("burst len", 1, act_n >= 1019 * MS && act_n <= 1022 * MS);
    repeat (2) @(posedge pclk);
    chk("done", 2'b11, {burst_done_fb, burst_done_led});
    chk("irq masked", 0, irq);
    apb(1, 8'h1C, 32'h2);
    chk("irq on", 1, irq);
    apb(0, 8'h14, 0); chk("irq stat", 2, rdata & 2);
    apb(1, 8'h18, 32'h1F);
    chk("irq clr", 0, irq);
    while (burst_done_fb === 1'b1) @(posedge pclk);
    chk("vstate end", 1, valve_state);
    // seat sensor fitted: the push ends on position, far short of the stroke time
    act0 = act_n;
    apb(1, 8'h00, 32'h13);
    plc.req_ms(600);
    chk("sensor end", 1, (act_n - act0) > 0 && (act_n - act0) < 5 * MS);
    chk("sensor done", 1, burst_done_fb);
    while (burst_done_fb === 1'b1) @(posedge pclk);
    apb(1, 8'h18, 32'h1F);
    apb(1, 8'h00, 32'h11);
    plc.req_ms(600);
    apb(0, 8'h14, 0); chk("refused", 4, rdata & 5);
    tally_and_finish();
  end
endmodule
bind scfs_ctrl scfs_ctrl_props #(.MS_CYCLES(MS_CYCLES)) u_props (.pclk(pclk),
  .presetn(presetn), .burst_req(burst_req), .err_valid(err_valid), .err_code(err_code),
  .burst_coil(burst_coil), .deenergized_closed_feedback(deenergized_closed_feedback),
  .feedback_input_zero(feedback_input_zero), .feedback_input_one(feedback_input_one),
  .valve_state(valve_state), .burst_active(burst_active), .burst_done_fb(burst_done_fb),
  .burst_done_led(burst_done_led), .irq(irq));
